// ---- dv/mic_indexer_chopper_bench.sv ----
`default_nettype none
module mic_indexer_chopper_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OFF_A = 40;
  localparam int OFF_B = 24;
  localparam int BLK_A = 6;
  localparam logic [31:0] FST_EXP = 32'h55000060;
  localparam logic [31:0] LST_EXP = 32'h55555000;
  logic clock, rstn, cyc, stb, we, go, fwd, clr_n, gate_n, wake_n, sr_n, oc;
  logic trip_a, trip_b, zc_a, zc_b, flt, ack, step, rdir, ss_hi, ss_lo, busy, org_n;
  logic [3:0] adr, wid, ga, gb, fst, lst;
  logic [1:0] size;
  logic [7:0] fref, ra, rb;
  logic [31:0] wdat, rdat, rd;
  logic [7:0] lv [8] = '{8'h00, 8'h00, 8'h35, 8'h36, 8'h40, 8'h90, 8'h9A, 8'hFF};
  int n_mismatch, checked, pos, span, nf, nf_long, n, i;

  mic_indexer_chopper i_dut (
    .clock(clock), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .step(step), .rotation_dir(rdir), .step_size_select_hi(ss_hi),
    .step_size_select_lo(ss_lo), .indexer_clear_n(clr_n), .bridge_output_gate_n(gate_n),
    .low_power_request_n(wake_n), .sync_rectify_n(sr_n), .overcurrent(oc),
    .trip_a(trip_a), .trip_b(trip_b), .zero_cross_a(zc_a), .zero_cross_b(zc_b),
    .origin_flag_n(org_n), .winding_a_outputs(ga), .winding_b_outputs(gb),
    .ref_code_a(ra), .ref_code_b(rb));

  mic_step_source i_src (
    .clock(clock), .rstn(rstn), .go(go), .fwd(fwd), .size(size), .width(wid),
    .step(step), .rotation_dir(rdir), .step_size_select_hi(ss_hi),
    .step_size_select_lo(ss_lo), .busy(busy));

  function automatic int pct(input int i);
    int mag[9] = '{100, 98, 92, 83, 71, 56, 38, 20, 0};
    int k;
    k = i % 16;
    k = (k > 8) ? mag[16 - k] : mag[k];
    return (i > 8 && i < 24) ? -k : k;
  endfunction

  function automatic logic [3:0] drv(input int p);
    return (p > 0) ? 4'h9 : (p < 0) ? 4'h6 : 4'h0;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t mismatch got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clock);
      k++;
    end while (ack !== 1'b1 && k < 20);
    chk(k < 20, 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic stp(input logic f, input logic [1:0] s);
    int k;
    k = 0;
    @(posedge clock);
    fwd <= f;
    size <= s;
    wid <= 4'($urandom_range(1, 8));
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    do begin
      @(posedge clock);
      k++;
    end while (busy !== 1'b0 && k < 40);
    if (clr_n && wake_n && !oc) pos = (pos + (f ? 1 : 31) * (1 << (3 - s))) % 32;
  endtask

  task automatic check_all(input logic en);
    int a, b;
    repeat (4) @(posedge clock);
    a = pct(pos);
    b = pct((pos + 24) % 32);
    wb(1'b0, 4'hC, 32'h0);
    chk(rd[4:0], pos[4:0]);
    chk({rd[6], org_n}, {2{pos != 4}});
    chk(rd[5], flt);
    chk(ra, (fref * (a < 0 ? -a : a) * 655) >> 16);
    chk(rb, (fref * (b < 0 ? -b : b) * 655) >> 16);
    chk(ga, en ? drv(a) : 4'h0);
    chk(gb, en ? drv(b) : 4'h0);
  endtask

  // one trip pulse, then record the off span seen at the gates
  task automatic probe(input logic b, output int sp, output int nfast,
                       output logic [3:0] f0, output logic [3:0] f1);
    logic [3:0] g, d;
    sp = 0;
    nfast = 0;
    f0 = 4'h0;
    f1 = 4'h0;
    d = drv(pct(b ? (pos + 24) % 32 : pos));
    repeat (30) @(posedge clock);
    if (b) trip_b <= 1'b1;
    else trip_a <= 1'b1;
    @(posedge clock);
    trip_a <= 1'b0;
    trip_b <= 1'b0;
    repeat ((b ? OFF_B : OFF_A) + 15) begin
      @(posedge clock);
      g = b ? gb : ga;
      if (g !== d) begin
        if (sp == 0) f0 = g;
        f1 = g;
        sp++;
        nfast += (g == 4'h0 || g == 4'h6);
        if (sp == 3 && b) zc_b <= 1'b1;
        if (sp == 3 && !b) zc_a <= 1'b1;
      end
    end
    zc_a <= 1'b0;
    zc_b <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    repeat (50000) @(posedge clock);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    {rstn, cyc, stb, we, go, fwd, oc, trip_a, trip_b, zc_a, zc_b, flt} = '0;
    {clr_n, gate_n, wake_n, sr_n} = 4'hB;
    {adr, wid, size, wdat} = '0;
    {n_mismatch, checked, pos} = {32'h0, 32'h0, 32'h4};
    fref = 8'hFF;
    void'($urandom(32'hA1BC9064));
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    check_all(1'b1);
    wb(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0000FFFF);
    wb(1'b1, 4'h2, 32'hFFFFFFFF);
    wb(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    fref = 8'($urandom_range(1, 255));
    wb(1'b1, 4'h0, 32'h00060028);
    wb(1'b1, 4'h4, 32'h00090018);
    wb(1'b1, 4'h8, {16'h0, fref, 8'hFF});
    for (i = 0; i < 48; i++) begin
      stp(1'($urandom_range(0, 1)), 2'(i));
      check_all(1'b1);
    end
    clr_n <= 1'b0;
    pos = 4;
    stp(1'b1, 2'h3);
    check_all(1'b0);
    clr_n <= 1'b1;
    stp(1'b1, 2'h3);
    // position 5: winding a target falls, winding b target rises
    for (i = 0; i < 8; i++) begin
      sr_n <= (i != 1);
      wb(1'b1, 4'h8, {16'h0, fref, lv[i]});
      probe(1'b0, span, nf, fst, lst);
      chk(span, OFF_A + 1);
      chk(fst, FST_EXP[i*4+:4]);
      chk(lst, LST_EXP[i*4+:4]);
      if (i == 4) nf_long = nf;
      if (i == 5) chk(nf_long > nf + 8, 1'b1);
    end
    wb(1'b1, 4'h8, {16'h0, fref, 8'h00});
    probe(1'b1, span, nf, fst, lst);
    chk(span, OFF_B + 1);
    chk({fst, lst}, 8'h55);
    // a held comparator may only end each drive phase once blanking has run out
    trip_a <= 1'b1;
    for (n = 0; n < 99 && ga === 4'h9; n++) @(posedge clock);
    for (n = 0; n < 99 && ga !== 4'h9; n++) @(posedge clock);
    for (n = 0; n < 99 && ga === 4'h9; n++) @(posedge clock);
    chk(n >= BLK_A && n <= BLK_A + 3, 1'b1);
    trip_a <= 1'b0;
    gate_n <= 1'b1;
    stp(1'b1, 2'h3);
    check_all(1'b0);
    wake_n <= 1'b0;
    gate_n <= 1'b0;
    stp(1'b1, 2'h3);
    repeat (3) @(posedge clock);
    chk({ga, gb, org_n}, 9'h001);
    wake_n <= 1'b1;
    check_all(1'b1);
    oc <= 1'b1;
    @(posedge clock);
    oc <= 1'b0;
    pos = 4;
    flt = 1'b1;
    stp(1'b0, 2'h3);
    check_all(1'b0);
    gate_n <= 1'b1;
    @(posedge clock);
    gate_n <= 1'b0;
    flt = 1'b0;
    check_all(1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ---- dv/mic_step_source.sv ----
`default_nettype none
module mic_step_source (
  input wire logic clock,
  input wire logic rstn,
  input wire logic go,
  input wire logic fwd,
  input wire logic [1:0] size,
  input wire logic [3:0] width,
  output logic step,
  output logic rotation_dir,
  output logic step_size_select_hi,
  output logic step_size_select_lo,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  assign cnt_next = cnt_reg - 5'h01;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      busy <= 1'b0;
      step <= 1'b0;
      cnt_reg <= 5'h00;
      rotation_dir <= 1'b1;
      {step_size_select_hi, step_size_select_lo} <= 2'h3;
    end else if (!busy) begin
      // settings move only while step is low, a cycle ahead of its rise, and hold after
      if (go) begin
        busy <= 1'b1;
        rotation_dir <= fwd;
        {step_size_select_hi, step_size_select_lo} <= size;
        cnt_reg <= {width, 1'b1};
      end
    end else begin
      cnt_reg <= cnt_next;
      // width cycles high then width cycles low; the rise comes the same cycle after go for any nonzero width, only the fall moves late
      step <= (cnt_next > {1'b0, width}) && (cnt_next <= {width, 1'b0});
      busy <= (cnt_next != 5'h00);
    end
  end
endmodule
`default_nettype wire

// ---- pkg/mic_pkg.sv ----
`default_nettype none
package mic_pkg;
  typedef enum logic [1:0] {
    DK_SLOW = 2'b00,
    DK_FAST = 2'b01,
    DK_MIXED = 2'b10
  } mic_decay_t;
  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_DRIVE = 2'b01,
    CH_FAST = 2'b10,
    CH_SLOW = 2'b11
  } mic_chop_t;
  typedef enum logic [1:0] {
    SS_FULL = 2'b00,
    SS_HALF = 2'b01,
    SS_QUARTER = 2'b10,
    SS_EIGHTH = 2'b11
  } mic_step_t;
endpackage
`default_nettype wire

// ---- pkg/mic_regs.svh ----
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH
`define MIC_CLK_MHZ 100
`define MIC_TOFF_NS 38000
`define MIC_TBLANK_NS 950
`define MIC_OFF_CYC ((`MIC_TOFF_NS * `MIC_CLK_MHZ) / 1000)
`define MIC_BLANK_CYC ((`MIC_TBLANK_NS * `MIC_CLK_MHZ + 999) / 1000)
`define MIC_TIMING_A_OFS 4'h0
`define MIC_TIMING_B_OFS 4'h4
`define MIC_DECAY_OFS 4'h8
`define MIC_STATUS_OFS 4'hC
`define MIC_OFF_LSB 0
`define MIC_BLANK_LSB 16
`define MIC_LEVEL_LSB 0
`define MIC_FULLREF_LSB 8
`define MIC_ST_POS_LSB 0
`define MIC_ST_FAULT_BIT 5
`define MIC_ST_ORIGIN_BIT 6
`define MIC_ST_FALL_LSB 7
`define MIC_ST_CHOP_LSB 9
`define MIC_DECAY_RST 16'hFFFF
`define MIC_HOME_POS 5'h04
`define MIC_SLOW_THR 8'h9A
`define MIC_FAST_THR 8'h36
`define MIC_PCT_RECIP 10'h28F
`endif

// ---- src/mic_bridge_chopper.sv ----
`default_nettype none
module mic_bridge_chopper (
  input wire logic clock,
  input wire logic rstn,
  input wire logic run,
  input wire logic negative,
  input wire logic trip,
  input wire logic zero_cross,
  input wire logic sync_rectify_n,
  input wire logic falling,
  input wire mic_pkg::mic_decay_t decay,
  input wire logic [15:0] off_cycles,
  input wire logic [15:0] blank_cycles,
  input wire logic [15:0] slow_at,
  output logic [3:0] gates,
  output mic_pkg::mic_chop_t state
);
  import mic_pkg::*;
  mic_chop_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [3:0] gates_reg, gates_next;
  wire use_fast = falling && (decay != DK_SLOW);
  wire cnt_done = cnt_reg == 16'h0000;
  wire to_slow = (decay == DK_MIXED) && (cnt_reg <= slow_at);
  wire [3:0] drive_pair = negative ? 4'b0110 : 4'b1001;
  wire [3:0] rev_pair = negative ? 4'b1001 : 4'b0110;
  assign gates = gates_reg;
  assign state = state_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_done ? cnt_reg : cnt_reg - 16'h0001;
    if (!run) begin
      state_next = CH_IDLE;
      cnt_next = 16'h0000;
    end else begin
      unique case (state_reg)
        CH_IDLE: begin
          state_next = CH_DRIVE;
          cnt_next = blank_cycles;
        end
        // comparator only counts once blanking has run out
        CH_DRIVE: if (cnt_done && trip) begin
          state_next = use_fast ? CH_FAST : CH_SLOW;
          cnt_next = off_cycles;
        end
        CH_FAST: if (cnt_done) begin
          state_next = CH_DRIVE;
          cnt_next = blank_cycles;
        end else if (to_slow) begin
          state_next = CH_SLOW;
        end
        CH_SLOW: if (cnt_done) begin
          state_next = CH_DRIVE;
          cnt_next = blank_cycles;
        end
      endcase
    end
  end

  // gates follow the next state so they line up with the state register
  always_comb begin
    unique case (state_next)
      CH_IDLE: gates_next = 4'h0;
      CH_DRIVE: gates_next = drive_pair;
      // diode recirculation, or reversed pair cut off near zero
      CH_FAST: gates_next = (sync_rectify_n || zero_cross) ? 4'h0 : rev_pair;
      CH_SLOW: gates_next = 4'b0101;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg <= CH_IDLE;
      cnt_reg <= 16'h0000;
      gates_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      gates_reg <= gates_next;
    end
  end

  property p_slow_gates;
    @(posedge clock) disable iff (!rstn)
    state_reg == CH_SLOW |-> gates_reg == 4'b0101;
  endproperty
  a_slow_gates: assert property (p_slow_gates) else $error("slow decay gates wrong");

  property p_blank_hold;
    @(posedge clock) disable iff (!rstn)
    (state_reg == CH_DRIVE && !cnt_done && run) |=> state_reg == CH_DRIVE;
  endproperty
  a_blank_hold: assert property (p_blank_hold) else $error("drive ended in blanking");

  property p_diode_decay;
    @(posedge clock) disable iff (!rstn)
    (state_reg == CH_FAST && sync_rectify_n) |=> (state_reg != CH_FAST || gates_reg == 4'h0);
  endproperty
  a_diode_decay: assert property (p_diode_decay) else $error("fets on in diode decay");
endmodule
`default_nettype wire

// ---- src/mic_indexer_chopper.sv ----
// What this block does
// - two select pins pick full, half, quarter or eighth step, held by controller
// - each rising step edge moves the position 8, 4, 2 or 1 table entries for full, half, quarter or eighth step
// - direction high steps forward, low steps backward through the same sequence
// - home is the 45 degree entry, entered at reset
// - origin flag is low at home, high everywhere else
// - eighth step magnitudes follow the sine table around the full circle
// - coarser modes use every 2nd, 4th or 8th entry through home
// - positive current drives terminal one high, negative reverses the bridge
// - full scale reference is scaled per winding by the present percentage
// - drive until comparator trips, then stop for a fixed off time
// - each bridge has its own off time and blanking setting
// - comparator ignored during blanking right after the bridge turns on
// - fast decay with rectify low reverses the bridge, off near zero current
// - fast decay with rectify high leaves every fet off
// - slow decay turns on both low side fets for the off time
// - mixed decay starts fast and goes slow after the fast interval
// - fast or mixed only while target current falls, otherwise slow
// - decay level picks slow above 0.6, fast below 0.21, else mixed
// - lower mixed decay level gives a longer fast portion
// - clear low holds home, disables bridges and ignores step edges
// - output gate high disables bridges while the indexer keeps running
// - low power request low disables bridges and freezes step, clear and overcurrent; output gate can still clear the fault latch
// - overcurrent sends home once and kills fets until gate goes high then low
`include "mic_regs.svh"
`default_nettype none
module mic_indexer_chopper (
  input wire logic clock,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic step,
  input wire logic rotation_dir,
  input wire logic step_size_select_hi,
  input wire logic step_size_select_lo,
  input wire logic indexer_clear_n,
  input wire logic bridge_output_gate_n,
  input wire logic low_power_request_n,
  input wire logic sync_rectify_n,
  input wire logic overcurrent,
  input wire logic trip_a,
  input wire logic trip_b,
  input wire logic zero_cross_a,
  input wire logic zero_cross_b,
  output logic origin_flag_n,
  output logic [3:0] winding_a_outputs,
  output logic [3:0] winding_b_outputs,
  output logic [7:0] ref_code_a,
  output logic [7:0] ref_code_b
);
  import mic_pkg::*;

  logic [31:0] timing_reg [2];
  logic [15:0] decay_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic step_prev_reg;
  logic [4:0] pos_reg, pos_next;
  logic fault_reg, fault_next;
  logic gate_seen_reg, gate_seen_next;
  logic origin_reg;
  // one element per bridge, each written only by its own generate process
  logic falling_reg [2];
  logic [7:0] ref_reg [2];
  logic [3:0] gates [2];
  mic_chop_t chop_state [2];

  // sine magnitudes in percent for 0..90 degrees in 11.25 degree steps
  function automatic logic [6:0] sin_mag(input logic [3:0] k);
    logic [6:0] m;
    m = 7'h00;
    unique case (k)
      4'h0: m = 7'h00;
      4'h1: m = 7'h14;
      4'h2: m = 7'h26;
      4'h3: m = 7'h38;
      4'h4: m = 7'h47;
      4'h5: m = 7'h53;
      4'h6: m = 7'h5C;
      4'h7: m = 7'h62;
      4'h8: m = 7'h64;
      default: m = 7'h00;
    endcase
    return m;
  endfunction

  // {sign, magnitude}; winding A is the cosine, winding B the sine
  function automatic logic [7:0] winding_pct(input logic [4:0] p, input logic is_b);
    logic [3:0] i;
    logic [3:0] idx;
    logic neg;
    i = {1'b0, p[2:0]};
    idx = (p[3] ^ is_b) ? i : 4'h8 - i;
    neg = is_b ? p[4] : p[4] ^ p[3];
    return {neg, sin_mag(idx)};
  endfunction

  // register bus decode
  wire bus_req = wb_cyc_i && wb_stb_i;
  wire wr_fire = bus_req && wb_we_i && ack_reg;
  wire hit_ta = wb_adr_i == `MIC_TIMING_A_OFS;
  wire hit_tb = wb_adr_i == `MIC_TIMING_B_OFS;
  wire hit_dk = wb_adr_i == `MIC_DECAY_OFS;
  wire hit_st = wb_adr_i == `MIC_STATUS_OFS;
  wire [31:0] lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                           {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [1:0] hit_t = {hit_tb, hit_ta};
  wire [31:0] decay_word = {16'h0000, decay_reg};
  wire [31:0] decay_merge = (decay_word & ~lane_mask) | (wb_dat_i & lane_mask);
  wire [7:0] level = decay_reg[`MIC_LEVEL_LSB +: 8];
  wire [7:0] full_ref = decay_reg[`MIC_FULLREF_LSB +: 8];

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`MIC_ST_POS_LSB +: 5] = pos_reg;
    status_word[`MIC_ST_FAULT_BIT] = fault_reg;
    status_word[`MIC_ST_ORIGIN_BIT] = origin_reg;
    status_word[`MIC_ST_FALL_LSB +: 2] = {falling_reg[1], falling_reg[0]};
    status_word[`MIC_ST_CHOP_LSB +: 4] = {chop_state[1], chop_state[0]};
  end

  wire [31:0] rd_data = hit_ta ? timing_reg[0] :
                        hit_tb ? timing_reg[1] :
                        hit_dk ? decay_word :
                        hit_st ? status_word : 32'h0000_0000;

  // one wait state: ack follows the request by one clock, then drops
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req && !ack_reg;
      dat_reg <= rd_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      decay_reg <= `MIC_DECAY_RST;
    end else if (wr_fire && hit_dk) begin
      decay_reg <= decay_merge[15:0];
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // indexer
  wire awake = low_power_request_n;
  wire step_rise = step && !step_prev_reg;
  wire [1:0] step_mode = {step_size_select_hi, step_size_select_lo};
  wire [1:0] stride_shift = 2'h3 - step_mode;
  wire [4:0] stride = 5'h01 << stride_shift;
  wire [4:0] pos_fwd = pos_reg + stride;
  wire [4:0] pos_rev = pos_reg - stride;
  wire [4:0] pos_step = rotation_dir ? pos_fwd : pos_rev;
  wire send_home = !indexer_clear_n || overcurrent;

  // asleep, every input is frozen out, the overcurrent sense included
  always_comb begin
    pos_next = pos_reg;
    if (awake && send_home) begin
      pos_next = `MIC_HOME_POS;
    end else if (awake && step_rise) begin
      pos_next = pos_step;
    end
  end

  // the latch only clears after a full high-then-low of the output gate
  always_comb begin
    fault_next = fault_reg;
    gate_seen_next = gate_seen_reg;
    if (fault_reg && gate_seen_reg && !bridge_output_gate_n) begin
      fault_next = 1'b0;
    end
    if (fault_reg && bridge_output_gate_n) begin
      gate_seen_next = 1'b1;
    end
    if (awake && overcurrent) begin
      fault_next = 1'b1;
      gate_seen_next = 1'b0;
    end
    if (!fault_next) begin
      gate_seen_next = 1'b0;
    end
  end

  // step history keeps running in sleep so waking never fakes an edge
  always_ff @(posedge clock) begin
    if (!rstn) begin
      step_prev_reg <= 1'b0;
      pos_reg <= `MIC_HOME_POS;
      origin_reg <= 1'b0;
      fault_reg <= 1'b0;
      gate_seen_reg <= 1'b0;
    end else begin
      step_prev_reg <= step;
      pos_reg <= pos_next;
      origin_reg <= pos_next != `MIC_HOME_POS;
      fault_reg <= fault_next;
      gate_seen_reg <= gate_seen_next;
    end
  end

  assign origin_flag_n = origin_reg;

  wire mic_decay_t decay_mode = (level >= `MIC_SLOW_THR) ? DK_SLOW :
                                (level < `MIC_FAST_THR) ? DK_FAST : DK_MIXED;
  // lower level means a deeper fast share; linear stand-in for the log law
  wire [7:0] fd_depth = `MIC_SLOW_THR - level;
  wire [1:0] trip_v = {trip_b, trip_a};
  wire [1:0] zc_v = {zero_cross_b, zero_cross_a};
  wire bridges_ok = awake && indexer_clear_n && !bridge_output_gate_n
                    && !fault_reg && !overcurrent;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_bridge
      wire [7:0] cur_pct = winding_pct(pos_reg, 1'(gi));
      wire [7:0] new_pct = winding_pct(pos_next, 1'(gi));
      wire [24:0] ref_prod = full_ref * new_pct[6:0] * `MIC_PCT_RECIP;
      wire [15:0] off_cyc = timing_reg[gi][`MIC_OFF_LSB +: 16];
      wire [15:0] blank_cyc = timing_reg[gi][`MIC_BLANK_LSB +: 16];
      wire [23:0] fd_prod = off_cyc * fd_depth;
      wire [15:0] fd_cyc = fd_prod[22:7];
      wire [15:0] slow_at = off_cyc - fd_cyc;
      wire [31:0] t_merge = (timing_reg[gi] & ~lane_mask) | (wb_dat_i & lane_mask);
      wire run = bridges_ok && (cur_pct[6:0] != 7'h00);

      always_ff @(posedge clock) begin
        if (!rstn) begin
          timing_reg[gi] <= {16'(`MIC_BLANK_CYC), 16'(`MIC_OFF_CYC)};
          falling_reg[gi] <= 1'b0;
          ref_reg[gi] <= 8'h00;
        end else begin
          if (wr_fire && hit_t[gi]) begin
            timing_reg[gi] <= t_merge;
          end
          if (pos_next != pos_reg) begin
            falling_reg[gi] <= new_pct[6:0] < cur_pct[6:0];
          end
          ref_reg[gi] <= full_ref == 8'h00 ? 8'h00 : ref_prod[23:16];
        end
      end

      mic_bridge_chopper u_chop (
        .clock(clock),
        .rstn(rstn),
        .run(run),
        .negative(cur_pct[7]),
        .trip(trip_v[gi]),
        .zero_cross(zc_v[gi]),
        .sync_rectify_n(sync_rectify_n),
        .falling(falling_reg[gi]),
        .decay(decay_mode),
        .off_cycles(off_cyc),
        .blank_cycles(blank_cyc),
        .slow_at(slow_at),
        .gates(gates[gi]),
        .state(chop_state[gi])
      );
    end
  endgenerate

  assign winding_a_outputs = gates[0];
  assign winding_b_outputs = gates[1];
  assign ref_code_a = ref_reg[0];
  assign ref_code_b = ref_reg[1];

  wire step_free = awake && indexer_clear_n && !overcurrent && step_rise;
  wire outs_off = (winding_a_outputs == 4'h0) && (winding_b_outputs == 4'h0);

  property p_home_reset;
    @(posedge clock) disable iff (!rstn)
    $rose(rstn) |-> pos_reg == `MIC_HOME_POS && !origin_flag_n;
  endproperty
  a_home_reset: assert property (p_home_reset) else $error("not home after reset");

  property p_origin;
    @(posedge clock) disable iff (!rstn)
    origin_flag_n == (pos_reg != `MIC_HOME_POS);
  endproperty
  a_origin: assert property (p_origin) else $error("origin flag mismatch");

  property p_step_move;
    @(posedge clock) disable iff (!rstn)
    step_free |=> pos_reg == $past(pos_step);
  endproperty
  a_step_move: assert property (p_step_move) else $error("step edge not taken");

  property p_reverse;
    @(posedge clock) disable iff (!rstn)
    (step_free && !rotation_dir) |=> 5'(pos_reg + $past(stride)) == $past(pos_reg);
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse step wrong");

  property p_full_stride;
    @(posedge clock) disable iff (!rstn)
    (step_free && step_mode == SS_FULL) |=> pos_reg[2:0] == $past(pos_reg[2:0]);
  endproperty
  a_full_stride: assert property (p_full_stride) else $error("full step stride wrong");

  property p_clear_hold;
    @(posedge clock) disable iff (!rstn)
    (!indexer_clear_n && awake)[*3] |-> pos_reg == `MIC_HOME_POS && outs_off;
  endproperty
  a_clear_hold: assert property (p_clear_hold) else $error("clear not honoured");

  property p_clear_home;
    @(posedge clock) disable iff (!rstn)
    (!indexer_clear_n && awake) |=> pos_reg == `MIC_HOME_POS;
  endproperty
  a_clear_home: assert property (p_clear_home) else $error("clear did not send home");

  property p_gate_off;
    @(posedge clock) disable iff (!rstn)
    bridge_output_gate_n[*3] |-> outs_off;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("bridge on while gated");

  property p_sleep_freeze;
    @(posedge clock) disable iff (!rstn)
    !low_power_request_n |=> $stable(pos_reg) && $stable(fault_reg);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze) else $error("state moved asleep");

  property p_ocp;
    @(posedge clock) disable iff (!rstn)
    (awake && overcurrent) |=> fault_reg && pos_reg == `MIC_HOME_POS ##1 outs_off;
  endproperty
  a_ocp: assert property (p_ocp) else $error("overcurrent not latched");
endmodule
`default_nettype wire
